// ### psr_pkg.sv
// Constants for the slot / root control register bank.
// Assumes a single clock domain and word-wide register ports.
package psr_pkg;
  localparam logic [1:0] PSR_IDX_SLOT_CAP = 2'h0;
  localparam logic [1:0] PSR_IDX_SLOT = 2'h1;
  localparam logic [1:0] PSR_IDX_ROOT = 2'h2;
  localparam logic [1:0] PSR_IDX_PME = 2'h3;
  localparam int PSR_CAP_NOCC = 18;
  localparam logic [31:0] PSR_SLOT_CAP_WMASK = 32'hffffffff;
  localparam int PSR_ST_DLL = 24;
  localparam int PSR_ST_LOCK = 23;
  localparam int PSR_ST_PRES = 22;
  localparam int PSR_ST_MRL = 21;
  localparam int PSR_ST_CC = 20;
  localparam int PSR_ST_PDC = 19;
  localparam int PSR_ST_MRLC = 18;
  localparam int PSR_ST_PF = 17;
  localparam int PSR_ST_ABP = 16;
  localparam int PSR_CT_DLLE = 12;
  localparam int PSR_CT_LOCK = 11;
  localparam int PSR_CT_PWR = 10;
  localparam int PSR_CT_HPIE = 5;
  localparam int PSR_CT_CCIE = 4;
  localparam logic [31:0] PSR_SLOT_RESET = 32'h000003c0;
  localparam logic [31:0] PSR_SLOT_CTL_MASK = 32'h00001fff;
  localparam logic [31:0] PSR_SLOT_LOCAL_ST = 32'h00e00000;
  localparam logic [31:0] PSR_SLOT_W1C_CFG = 32'h011f0000;
  localparam logic [31:0] PSR_SLOT_W1C_LOC = 32'h01000000;
  localparam logic [31:0] PSR_SLOT_LOCAL_RW = 32'h001f0000;
  localparam int PSR_RC_CRS = 16;
  localparam int PSR_RC_CRSE = 4;
  localparam int PSR_RC_PMEE = 3;
  localparam int PSR_RC_FATE = 2;
  localparam int PSR_RC_NFE = 1;
  localparam int PSR_RC_CORE = 0;
  localparam logic [31:0] PSR_ROOT_WMASK = 32'h0000001f;
  localparam int PSR_PME_PEND = 17;
  localparam int PSR_PME_STAT = 16;
endpackage

// ### psr_evt_if.sv
// State levels handed from the bank to its edge-detect helper; change strobes come back.
// Assumes both ends sit on clk_sys.
`timescale 1ns/1ps
interface psr_evt_if;
  logic link_active_flag;
  logic presence;
  logic mrl;
  logic link_chg;
  logic pres_chg;
  logic mrl_chg;
  modport bank (output link_active_flag, output presence, output mrl, input link_chg, input pres_chg, input mrl_chg);
  modport det (input link_active_flag, input presence, input mrl, output link_chg, output pres_chg, output mrl_chg);
endinterface

// ### psr_change_det.sv
// Change detector for the link-active flag and the presence and MRL slot state bits.
// Assumes inputs are already on clk_sys.
`timescale 1ns/1ps
module psr_change_det import psr_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  psr_evt_if.det ev
);
  typedef struct packed {
    logic link;
    logic pres;
    logic mrl;
  } psr_det_t;
  psr_det_t det_reg;
  psr_det_t det_next;
  always_comb begin
    det_next.link = ev.link_active_flag;
    det_next.pres = ev.presence;
    det_next.mrl = ev.mrl;
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      det_reg <= '0;
    end else begin
      det_reg <= det_next;
    end
  end
  // Both edges count as a change
  assign ev.link_chg = det_reg.link ^ ev.link_active_flag;
  assign ev.pres_chg = det_reg.pres ^ ev.presence;
  assign ev.mrl_chg = det_reg.mrl ^ ev.mrl;
endmodule

// ### psr_slot_root_regs.sv
// Slot status/control and root control/status register bank.
// Assumes a local CPU port and a config-request port, both on clk_sys,
// and slot/link event inputs already synchronous to clk_sys except the
// link state, which is synchronised here.
// Overview of operation
// - Slot presence bits local-writable, config read-only
// - Link change flag, clear by either side
// - Slot state bits set by local software
// - Command complete set unless unsupported
// - Presence changed flag, write-one clears
// - MRL changed flag, write-one clears
// - Power fault, button pressed; config clears
// - Bit 12 gates link change flag
// - Bit 11 toggles interlock; resets zero
// - Bit 10 drives slot power; resets zero
// - Indicators: 01 on, 10 blink, 11 off
// - Slot event interrupts need event and master enable; command complete needs only bit 4
// - Bit 4 enables command complete interrupt
// - Root capability bit 16 reads one
// - Retry completion raises system error when enabled
// - PME interrupt when enabled
// - Error interrupts enabled per severity
// - Reserved bits read zero
// - PME status set on PME, W1C
// - PME requester ID captured
// - PME pending; re-arm after clear
// - Link active while link machine active
`timescale 1ns/1ps
module psr_slot_root_regs import psr_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic loc_wr,
  input wire logic [1:0] loc_idx,
  input wire logic [31:0] loc_wdata,
  output logic [31:0] loc_rdata,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_idx,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic link_ctrl_active,
  input wire logic cmd_done,
  input wire logic power_fault,
  input wire logic button_press,
  input wire logic crs_received,
  input wire logic pme_received,
  input wire logic [15:0] pme_req_id,
  input wire logic err_fatal,
  input wire logic err_nonfatal,
  input wire logic err_corr,
  output logic hotplug_irq,
  output logic system_error_irq,
  output logic pme_irq,
  output logic err_irq,
  output logic slot_power_on,
  output logic interlock_toggle,
  output logic [1:0] power_ind,
  output logic [1:0] attn_ind,
  output logic link_active_flag
);

  typedef struct packed {
    logic link_s1;
    logic link_s2;
    logic [31:0] slot_cap;
    logic [31:0] slot;
    logic [4:0] root;
    logic pme_stat;
    logic pme_pend;
    logic [15:0] pme_id;
    logic [15:0] pend_id;
    logic sys_err;
    logic pme_int;
    logic err_int;
    logic lock_tgl;
  } psr_state_t;

  psr_state_t st_reg;
  psr_state_t st_next;
  psr_evt_if ev ();

  // The link state comes from the MAC side; two flops before use
  assign ev.link_active_flag = st_reg.link_s2;
  assign ev.presence = st_reg.slot[PSR_ST_PRES];
  assign ev.mrl = st_reg.slot[PSR_ST_MRL];

  psr_change_det u_det (
    .clk_sys(clk_sys),
    .reset(reset),
    .ev(ev)
  );

  function automatic logic [31:0] read_word(input psr_state_t s, input logic [1:0] idx);
    logic [31:0] r;
    r = '0;
    case (idx)
      PSR_IDX_SLOT_CAP: r = s.slot_cap;
      PSR_IDX_SLOT: r = s.slot & (PSR_SLOT_W1C_CFG | PSR_SLOT_LOCAL_ST | PSR_SLOT_CTL_MASK);
      PSR_IDX_ROOT: begin
        r[PSR_RC_CRS] = 1'b1;
        r[4:0] = s.root;
      end
      PSR_IDX_PME: begin
        r[PSR_PME_PEND] = s.pme_pend;
        r[PSR_PME_STAT] = s.pme_stat;
        r[15:0] = s.pme_id;
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  logic l_slot;
  logic c_slot;
  logic [31:0] w1c;
  logic [31:0] set_ev;
  logic pme_clr;

  always_comb begin
    st_next = st_reg;
    st_next.link_s1 = link_ctrl_active;
    st_next.link_s2 = st_reg.link_s1;
    l_slot = loc_wr && (loc_idx == PSR_IDX_SLOT);
    c_slot = cfg_wr && (cfg_idx == PSR_IDX_SLOT);
    // Slot capability: local only, config writes ignored
    if (loc_wr && (loc_idx == PSR_IDX_SLOT_CAP)) begin
      st_next.slot_cap = loc_wdata & PSR_SLOT_CAP_WMASK;
    end
    // Control half: both sides may write; local wins a same-cycle collision
    if (c_slot) begin
      st_next.slot[12:0] = cfg_wdata[12:0];
    end
    if (l_slot) begin
      st_next.slot[12:0] = loc_wdata[12:0];
      st_next.slot[23:21] = loc_wdata[23:21];
      // Local side writes event flags directly except the link flag
      st_next.slot[20:16] = loc_wdata[20:16];
    end
    // Reserved indicator code 00 is stored as written; decoding left to the slot
    w1c = '0;
    if (c_slot) begin
      w1c = w1c | (cfg_wdata & PSR_SLOT_W1C_CFG);
    end
    if (l_slot) begin
      w1c = w1c | (loc_wdata & PSR_SLOT_W1C_LOC);
    end
    st_next.slot = st_next.slot & ~w1c;
    // Hardware sets beat clears in the same cycle
    set_ev = '0;
    set_ev[PSR_ST_DLL] = ev.link_chg && st_reg.slot[PSR_CT_DLLE];
    set_ev[PSR_ST_CC] = cmd_done && !st_reg.slot_cap[PSR_CAP_NOCC];
    set_ev[PSR_ST_PDC] = ev.pres_chg;
    set_ev[PSR_ST_MRLC] = ev.mrl_chg;
    set_ev[PSR_ST_PF] = power_fault;
    set_ev[PSR_ST_ABP] = button_press;
    st_next.slot = (st_next.slot | set_ev) & (PSR_SLOT_W1C_CFG | PSR_SLOT_LOCAL_ST | PSR_SLOT_CTL_MASK);
    // Interlock command is a one-cycle pulse on each write of 1
    st_next.lock_tgl = (l_slot && loc_wdata[PSR_CT_LOCK]) || (!l_slot && c_slot && cfg_wdata[PSR_CT_LOCK]);
    // Root control
    if (cfg_wr && (cfg_idx == PSR_IDX_ROOT)) begin
      st_next.root = cfg_wdata[4:0] & PSR_ROOT_WMASK[4:0];
    end
    if (loc_wr && (loc_idx == PSR_IDX_ROOT)) begin
      st_next.root = loc_wdata[4:0] & PSR_ROOT_WMASK[4:0];
    end
    // Root status: config side may only clear the status bit
    pme_clr = (cfg_wr && (cfg_idx == PSR_IDX_PME) && cfg_wdata[PSR_PME_STAT]) ||
              (loc_wr && (loc_idx == PSR_IDX_PME) && loc_wdata[PSR_PME_STAT]);
    if (loc_wr && (loc_idx == PSR_IDX_PME)) begin
      st_next.pme_pend = loc_wdata[PSR_PME_PEND];
      st_next.pme_id = loc_wdata[15:0];
    end
    if (pme_clr) begin
      st_next.pme_stat = 1'b0;
      if (st_reg.pme_pend) begin
        st_next.pme_stat = 1'b1;
        st_next.pme_id = st_reg.pend_id;
        st_next.pme_pend = 1'b0;
      end
    end
    if (pme_received) begin
      if (st_reg.pme_stat && !pme_clr) begin
        st_next.pme_pend = 1'b1;
        st_next.pend_id = pme_req_id;
      end else if (!st_next.pme_stat) begin
        st_next.pme_stat = 1'b1;
        st_next.pme_id = pme_req_id;
      end else begin
        st_next.pme_pend = 1'b1;
        st_next.pend_id = pme_req_id;
      end
    end
    st_next.sys_err = crs_received && st_reg.root[PSR_RC_CRSE];
    st_next.pme_int = pme_received && st_reg.root[PSR_RC_PMEE];
    st_next.err_int = (err_fatal && st_reg.root[PSR_RC_FATE]) ||
                      (err_nonfatal && st_reg.root[PSR_RC_NFE]) ||
                      (err_corr && st_reg.root[PSR_RC_CORE]);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.slot <= PSR_SLOT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign loc_rdata = read_word(st_reg, loc_idx);
  assign cfg_rdata = read_word(st_reg, cfg_idx);
  assign link_active_flag = st_reg.link_s2;
  assign slot_power_on = st_reg.slot[PSR_CT_PWR];
  assign interlock_toggle = st_reg.lock_tgl;
  assign power_ind = st_reg.slot[9:8];
  assign attn_ind = st_reg.slot[7:6];
  // Level interrupt: stays up while a flag and its enables are set
  assign hotplug_irq = (st_reg.slot[PSR_CT_HPIE] && |(st_reg.slot[19:16] & st_reg.slot[3:0])) ||
                       (st_reg.slot[PSR_CT_CCIE] && st_reg.slot[PSR_ST_CC]);
  assign system_error_irq = st_reg.sys_err;
  assign pme_irq = st_reg.pme_int;
  assign err_irq = st_reg.err_int;

  sequence crs_seen_s;
    crs_received && st_reg.root[PSR_RC_CRSE];
  endsequence

  sequence sys_err_s;
    system_error_irq;
  endsequence

  sequence lock_cmd_s;
    (l_slot && loc_wdata[PSR_CT_LOCK]) || (c_slot && !l_slot && cfg_wdata[PSR_CT_LOCK]);
  endsequence

  sequence pme_rearm_s;
    pme_clr && st_reg.pme_pend;
  endsequence

  // A clear only sticks when no link change lands in the same cycle
  sequence dll_clr_s;
    ((l_slot && loc_wdata[PSR_ST_DLL]) || (c_slot && cfg_wdata[PSR_ST_DLL])) &&
    !(ev.link_chg && st_reg.slot[PSR_CT_DLLE]);
  endsequence

  crs_serr_a: assert property (@(posedge clk_sys) disable iff (reset) crs_seen_s |=> sys_err_s)
    else $error("retry completion did not raise system error");
  pme_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    pme_received && !st_reg.pme_stat |=> st_reg.pme_stat && st_reg.pme_id == $past(pme_req_id))
    else $error("PME status or ID not captured");
  pme_pend_a: assert property (@(posedge clk_sys) disable iff (reset)
    pme_received && st_reg.pme_stat && !pme_clr |=> st_reg.pme_pend)
    else $error("PME pending not set");
  cap_const_a: assert property (@(posedge clk_sys) disable iff (reset)
    loc_idx == PSR_IDX_ROOT |-> loc_rdata[PSR_RC_CRS] && loc_rdata[31:17] == '0)
    else $error("root capability bit wrong");
  slot_rsvd_a: assert property (@(posedge clk_sys) disable iff (reset)
    cfg_idx == PSR_IDX_SLOT |-> cfg_rdata[31:25] == '0 && cfg_rdata[15:13] == '0)
    else $error("reserved slot bits nonzero");
  cap_ro_a: assert property (@(posedge clk_sys) disable iff (reset)
    cfg_wr && cfg_idx == PSR_IDX_SLOT_CAP && !loc_wr |=> $stable(st_reg.slot_cap))
    else $error("config write changed capability");
  cc_block_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_reg.slot_cap[PSR_CAP_NOCC] && !st_reg.slot[PSR_ST_CC] && !l_slot |=> !st_reg.slot[PSR_ST_CC])
    else $error("command complete set while unsupported");
  pres_chg_a: assert property (@(posedge clk_sys) disable iff (reset)
    ev.pres_chg |=> st_reg.slot[PSR_ST_PDC])
    else $error("presence change not flagged");
  link_sync_a: assert property (@(posedge clk_sys) disable iff (reset)
    link_ctrl_active [*3] |-> link_active_flag)
    else $error("link active flag did not follow");
  hp_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
    !st_reg.slot[PSR_CT_HPIE] && !st_reg.slot[PSR_CT_CCIE] |-> !hotplug_irq)
    else $error("hot-plug interrupt without master enable");
  w1c_pf_a: assert property (@(posedge clk_sys) disable iff (reset)
    c_slot && cfg_wdata[PSR_ST_PF] && !l_slot && !power_fault |=> !st_reg.slot[PSR_ST_PF])
    else $error("power fault flag not cleared");
  pf_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    power_fault |=> st_reg.slot[PSR_ST_PF])
    else $error("power fault not flagged");
  abp_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    button_press |=> st_reg.slot[PSR_ST_ABP])
    else $error("button press not flagged");
  cc_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_done && !st_reg.slot_cap[PSR_CAP_NOCC] |=> st_reg.slot[PSR_ST_CC])
    else $error("command complete not flagged");
  mrl_chg_a: assert property (@(posedge clk_sys) disable iff (reset)
    ev.mrl_chg |=> st_reg.slot[PSR_ST_MRLC])
    else $error("MRL change not flagged");
  dll_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    ev.link_chg && st_reg.slot[PSR_CT_DLLE] |=> st_reg.slot[PSR_ST_DLL])
    else $error("link change not flagged");
  dll_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
    !st_reg.slot[PSR_CT_DLLE] && !st_reg.slot[PSR_ST_DLL] |=> !st_reg.slot[PSR_ST_DLL])
    else $error("link change flagged while disabled");
  dll_clr_a: assert property (@(posedge clk_sys) disable iff (reset)
    dll_clr_s |=> !st_reg.slot[PSR_ST_DLL])
    else $error("link change flag not cleared");
  state_ro_a: assert property (@(posedge clk_sys) disable iff (reset)
    c_slot && !l_slot |=> $stable(st_reg.slot[PSR_ST_LOCK:PSR_ST_MRL]))
    else $error("config write changed slot state");
  state_wr_a: assert property (@(posedge clk_sys) disable iff (reset)
    l_slot |=> st_reg.slot[PSR_ST_LOCK:PSR_ST_MRL] == $past(loc_wdata[PSR_ST_LOCK:PSR_ST_MRL]))
    else $error("slot state not stored");
  pwr_wr_a: assert property (@(posedge clk_sys) disable iff (reset)
    l_slot |=> slot_power_on == $past(loc_wdata[PSR_CT_PWR]))
    else $error("power control not driven");
  lock_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
    lock_cmd_s |=> interlock_toggle)
    else $error("interlock toggle missing");
  lock_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    !l_slot && !c_slot |=> !interlock_toggle)
    else $error("interlock toggle without write");
  ind_wr_a: assert property (@(posedge clk_sys) disable iff (reset)
    c_slot && !l_slot |=> power_ind == $past(cfg_wdata[9:8]) && attn_ind == $past(cfg_wdata[7:6]))
    else $error("indicator field not driven");
  pme_irq_a: assert property (@(posedge clk_sys) disable iff (reset)
    pme_received && st_reg.root[PSR_RC_PMEE] |=> pme_irq)
    else $error("PME interrupt missing");
  pme_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
    !pme_received |=> !pme_irq)
    else $error("PME interrupt without message");
  err_fat_a: assert property (@(posedge clk_sys) disable iff (reset)
    err_fatal && st_reg.root[PSR_RC_FATE] |=> err_irq)
    else $error("fatal error interrupt missing");
  err_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
    !err_fatal && !err_nonfatal && !err_corr |=> !err_irq)
    else $error("error interrupt without error");
  serr_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
    !crs_received |=> !system_error_irq)
    else $error("system error without retry completion");
  pme_rearm_a: assert property (@(posedge clk_sys) disable iff (reset)
    pme_rearm_s |=> st_reg.pme_stat && st_reg.pme_id == $past(st_reg.pend_id))
    else $error("pending PME not reloaded");
  pme_clr_a: assert property (@(posedge clk_sys) disable iff (reset)
    pme_clr && !st_reg.pme_pend && !pme_received |=> !st_reg.pme_stat)
    else $error("PME status not cleared");
  root_rsvd_a: assert property (@(posedge clk_sys) disable iff (reset)
    cfg_idx == PSR_IDX_ROOT |-> cfg_rdata[15:5] == '0)
    else $error("reserved root bits nonzero");
  hp_ev_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_reg.slot[PSR_CT_HPIE] && st_reg.slot[PSR_ST_PF] && st_reg.slot[1] |-> hotplug_irq)
    else $error("power fault interrupt missing");
  cc_irq_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_reg.slot[PSR_CT_CCIE] && st_reg.slot[PSR_ST_CC] |-> hotplug_irq)
    else $error("command complete interrupt missing");
  link_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
    !link_ctrl_active [*3] |-> !link_active_flag)
    else $error("link active flag did not drop");
  cap_wr_a: assert property (@(posedge clk_sys) disable iff (reset)
    loc_wr && loc_idx == PSR_IDX_SLOT_CAP |=> st_reg.slot_cap == $past(loc_wdata))
    else $error("capability write not stored");
endmodule

// ### psr_slot_model.sv
// Far-side model: slot hardware and link partner as event sources.
// Assumes the bench calls its tasks just after a falling edge of clk_sys.
`timescale 1ns/1ps
module psr_slot_model (
  input wire logic clk_sys,
  output logic link_up,
  output logic [7:0] ev,
  output logic [15:0] req_id
);
  initial begin
    link_up = 1'b0;
    ev = 8'h00;
    req_id = 16'h0000;
  end
  // Events last one clock; the ID is scrambled after so a stale value cannot pass
  task automatic fire(input logic [7:0] which, input logic [15:0] id);
    ev = which;
    req_id = id;
    @(negedge clk_sys);
    ev = 8'h00;
    req_id = ~id;
  endtask
  task automatic set_link(input logic up);
    link_up = up;
  endtask
endmodule

// ### test_psr_slot_root_regs.sv
// Self-checking bench for the slot / root register bank.
// Assumes the local and config ports behave as single-cycle write strobes.
`timescale 1ns/1ps
module test_psr_slot_root_regs;
  import psr_pkg::*;
  logic clk_sys, reset, loc_wr, cfg_wr, hotplug_irq, system_error_irq, pme_irq, err_irq;
  logic slot_power_on, interlock_toggle, link_active_flag, link_up;
  logic [1:0] loc_idx, cfg_idx, power_ind, attn_ind;
  logic [31:0] loc_wdata, cfg_wdata, loc_rdata, cfg_rdata;
  logic [7:0] ev;
  logic [15:0] req_id;
  logic [3:0] seen;
  int n_fail, n_compared, cyc;
  psr_slot_model slot (.clk_sys(clk_sys), .link_up(link_up), .ev(ev), .req_id(req_id));
  psr_slot_root_regs dut (.clk_sys(clk_sys), .reset(reset), .loc_wr(loc_wr), .loc_idx(loc_idx),
    .loc_wdata(loc_wdata), .loc_rdata(loc_rdata), .cfg_wr(cfg_wr), .cfg_idx(cfg_idx),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .link_ctrl_active(link_up), .cmd_done(ev[0]),
    .power_fault(ev[1]), .button_press(ev[2]), .crs_received(ev[3]), .pme_received(ev[4]),
    .pme_req_id(req_id), .err_fatal(ev[5]), .err_nonfatal(ev[6]), .err_corr(ev[7]),
    .hotplug_irq(hotplug_irq), .system_error_irq(system_error_irq), .pme_irq(pme_irq),
    .err_irq(err_irq), .slot_power_on(slot_power_on), .interlock_toggle(interlock_toggle),
    .power_ind(power_ind), .attn_ind(attn_ind), .link_active_flag(link_active_flag));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Pulsed outputs are caught in sticky bits so a one-cycle pulse is never missed
  always @(posedge clk_sys) begin
    seen <= seen | {err_irq, pme_irq, system_error_irq, interlock_toggle};
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  // One strobe cycle, then one idle cycle so event flags have landed
  task automatic wr(input bit cfg, input logic [1:0] idx, input logic [31:0] d);
    cfg_wr = cfg;
    loc_wr = !cfg;
    cfg_idx = idx;
    loc_idx = idx;
    cfg_wdata = d;
    loc_wdata = d;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
    loc_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic chk(input bit cfg, input logic [1:0] idx, input logic [31:0] exp);
    cfg_idx = idx;
    loc_idx = idx;
    #1;
    cmp(cfg ? cfg_rdata : loc_rdata, exp);
  endtask
  task automatic done_t(input string name);
    $display("test %s done", name);
  endtask
  initial begin
    {loc_wr, cfg_wr, loc_idx, cfg_idx, loc_wdata, cfg_wdata} = '0;
    reset = 1'b1;
    seen = 4'h0;
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    chk(0, PSR_IDX_SLOT, PSR_SLOT_RESET);
    chk(1, PSR_IDX_ROOT, 32'h00010000);
    chk(1, PSR_IDX_PME, 32'h00000000);
    cmp(32'({power_ind, attn_ind, slot_power_on}), 32'h1e);
    done_t("reset");
    wr(0, PSR_IDX_SLOT_CAP, 32'h00000007);
    chk(1, PSR_IDX_SLOT_CAP, 32'h00000007);
    wr(1, PSR_IDX_SLOT_CAP, 32'h00000000);
    chk(0, PSR_IDX_SLOT_CAP, 32'h00000007);
    wr(0, PSR_IDX_ROOT, 32'hffffffff);
    chk(1, PSR_IDX_ROOT, 32'h0001001f);
    done_t("access");
    wr(0, PSR_IDX_SLOT, 32'hfee0e3c0);
    chk(1, PSR_IDX_SLOT, 32'h00ec03c0);
    wr(1, PSR_IDX_SLOT, 32'h000c03c0);
    chk(0, PSR_IDX_SLOT, 32'h00e003c0);
    wr(1, PSR_IDX_SLOT, 32'h00e003e3);
    slot.fire(8'h02, 16'h0000);
    chk(0, PSR_IDX_SLOT, 32'h00e203e3);
    cmp(32'(hotplug_irq), 32'h1);
    wr(1, PSR_IDX_SLOT, 32'h00e203c3);
    slot.fire(8'h04, 16'h0000);
    chk(0, PSR_IDX_SLOT, 32'h00e103c3);
    cmp(32'(hotplug_irq), 32'h0);
    wr(1, PSR_IDX_SLOT, 32'h00e103d0);
    slot.fire(8'h01, 16'h0000);
    chk(0, PSR_IDX_SLOT, 32'h00f003d0);
    cmp(32'(hotplug_irq), 32'h1);
    wr(1, PSR_IDX_SLOT, 32'h001003d0);
    wr(0, PSR_IDX_SLOT_CAP, 32'h00040007);
    slot.fire(8'h01, 16'h0000);
    chk(0, PSR_IDX_SLOT, 32'h00e003d0);
    cmp(32'(hotplug_irq), 32'h0);
    done_t("hotplug");
    wr(0, PSR_IDX_SLOT, 32'h00e013c0);
    slot.set_link(1'b1);
    repeat (5) @(negedge clk_sys);
    cmp(32'(link_active_flag), 32'h1);
    chk(1, PSR_IDX_SLOT, 32'h01e013c0);
    wr(0, PSR_IDX_SLOT, 32'h01e003c0);
    chk(1, PSR_IDX_SLOT, 32'h00e003c0);
    slot.set_link(1'b0);
    repeat (5) @(negedge clk_sys);
    cmp(32'(link_active_flag), 32'h0);
    chk(1, PSR_IDX_SLOT, 32'h00e003c0);
    done_t("link");
    for (int k = 0; k < 3; k++) begin
      wr(1, PSR_IDX_ROOT, 32'h1 << k);
      seen = 4'h0;
      slot.fire(8'he0 & ~(8'h80 >> k), 16'h0000);
      repeat (2) @(negedge clk_sys);
      cmp(32'(seen), 32'h0);
      slot.fire(8'h80 >> k, 16'h0000);
      repeat (2) @(negedge clk_sys);
      cmp(32'(seen), 32'h8);
    end
    wr(1, PSR_IDX_ROOT, 32'h00000000);
    seen = 4'h0;
    slot.fire(8'h18, 16'h0000);
    wr(1, PSR_IDX_ROOT, 32'h00000018);
    cmp(32'(seen), 32'h0);
    slot.fire(8'h08, 16'h0000);
    repeat (2) @(negedge clk_sys);
    cmp(32'(seen), 32'h2);
    done_t("root_irq");
    wr(1, PSR_IDX_PME, 32'h00010000);
    chk(0, PSR_IDX_PME, 32'h00000000);
    slot.fire(8'h10, 16'h1234);
    repeat (2) @(negedge clk_sys);
    chk(0, PSR_IDX_PME, 32'h00011234);
    cmp(32'(seen[2]), 32'h1);
    slot.fire(8'h10, 16'h5678);
    chk(1, PSR_IDX_PME, 32'h00031234);
    wr(1, PSR_IDX_PME, 32'h00010000);
    chk(0, PSR_IDX_PME, 32'h00015678);
    done_t("pme");
    for (int c = 1; c < 4; c++) begin
      wr(1, PSR_IDX_SLOT, 32'h00e00000 | (c << 8) | (c << 6));
      cmp(32'({power_ind, attn_ind}), 32'((c << 2) | c));
    end
    seen = 4'h0;
    wr(0, PSR_IDX_SLOT, 32'h00e00d40);
    cmp(32'({slot_power_on, seen[0], power_ind, attn_ind}), 32'h35);
    done_t("controls");
    print_verdict();
  end
endmodule
